// ### rtl/i2c_slave_defines.vh
// register indices, field positions, reset values and timing counts
// assumes a plain one-cycle register port in front of the slave core
`ifndef I2C_SLAVE_DEFINES_VH
`define I2C_SLAVE_DEFINES_VH

// register indices on the 3-bit register port
`define REG_MODE_ENABLE_CONTROL     3'h0
`define REG_TRANSFER_STATUS_CONTROL 3'h1
`define REG_SERIAL_DATA_BYTE        3'h2
`define REG_OWN_SLAVE_ADDRESS       3'h3
`define REG_BUS_TIMEOUT_CONTROL     3'h4
`define REG_IRQ_STATUS              3'h5
`define REG_IRQ_MASK                3'h6
`define REG_PULLUP_CONTROL          3'h7

// mode_enable_control fields
`define MODE_FIELD_HI   7
`define MODE_FIELD_LO   5
`define DEB_FIELD_HI    3
`define DEB_FIELD_LO    2
`define ENABLE_BIT      1
`define MODE_SLAVE      3'h6
`define MODE_RESET      8'hE0

// transfer_status_control fields
`define DONE_BIT        7
`define MATCH_BIT       6
`define BUSY_BIT        5
`define HTX_BIT         4
`define TXAK_BIT        3
`define DIR_BIT         2
`define WAKE_BIT        1
`define RXAK_BIT        0
`define STATUS_RESET    8'h81

// interrupt status and mask bits
`define IRQ_DONE_BIT    0
`define IRQ_MATCH_BIT   1

// other reset values
`define ADDR_RESET      8'h00
`define DATA_RESET      8'h00
`define TOC_RESET       8'h00
`define PULLUP_RESET    2'h0

// debounce lengths in system clocks
`define DEB_SHORT       3'h2
`define DEB_LONG        3'h4

`endif

// ### rtl/line_sync.v
// two flip-flop synchroniser with optional debounce of the settled level
// assumes din comes from a pin outside the clk domain
`timescale 1ns/10ps
`default_nettype none
module line_sync (
    // clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // line and filter length (0 means none)
    input  wire       din,
    input  wire [2:0] deb_len,
    // filtered level
    output reg        dout
);
    reg       meta_r;
    reg       sync_r;
    reg [2:0] cnt_r;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            cnt_r  <= 3'h0;
            dout   <= 1'b1;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            if (sync_r == dout) begin
                cnt_r <= 3'h0;
            end else if (cnt_r + 3'h1 >= deb_len || deb_len == 3'h0) begin
                dout  <= sync_r;
                cnt_r <= 3'h0;
            end else begin
                cnt_r <= cnt_r + 3'h1;
            end
        end
    end
endmodule // line_sync
`default_nettype wire

// ### rtl/bit_engine.v
// finds start, stop and clock edges on the filtered two-wire lines
// assumes scl and sda are already synchronised and scl is debounced
`timescale 1ns/10ps
`default_nettype none
module bit_engine (
    // clock and reset
    input  wire clk,
    input  wire rst_b,
    // filtered lines
    input  wire scl,
    input  wire sda,
    // events, one cycle each
    output reg  scl_rise,
    output reg  scl_fall,
    output reg  start_seen,
    output reg  stop_seen
);
    reg scl_d_r;
    reg sda_d_r;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
            scl_rise   <= 1'b0;
            scl_fall   <= 1'b0;
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
        end else begin
            scl_d_r    <= scl;
            sda_d_r    <= sda;
            scl_rise   <= scl & ~scl_d_r;
            scl_fall   <= ~scl & scl_d_r;
            start_seen <= scl & scl_d_r & sda_d_r & ~sda;
            stop_seen  <= scl & scl_d_r & ~sda_d_r & sda;
        end
    end
endmodule // bit_engine
`default_nettype wire

// ### rtl/i2c_slave_interface.v
// slave-only two-wire serial interface with an 8-register software port
// assumes an external master owns the clock line; pins are open drain
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_defines.vh"
module i2c_slave_interface (
    // clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // register port
    input  wire [2:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // serial clock pin
    input  wire       scl_in,
    output reg        scl_out,
    output reg        scl_oe_b,
    // serial data pin
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe_b,
    // pin pull-up enables
    output reg        scl_pullup_en,
    output reg        sda_pullup_en,
    // interrupt
    output reg        irq
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_DACK = 3'h4;
    localparam ST_SKIP = 3'h5;

    reg [7:0] mode_r;
    reg [7:0] stat_r;
    reg [7:0] data_r;
    reg [7:0] addr_r;
    reg [7:0] toc_r;
    reg [1:0] irq_stat_r;
    reg [1:0] irq_mask_r;
    reg [1:0] pullup_r;
    reg [2:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg       sda_low_r;
    reg       en_d_r;

    wire       scl_f;
    wire       sda_f;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_seen;
    wire       stop_seen;
    reg  [2:0] deb_len;
    wire       active;
    wire       wr_mode;
    wire       wr_stat;
    wire       wr_data;
    wire       wr_irq;
    wire       ev_done;
    wire       ev_match;
    wire [7:0] rx_byte;

    // debounce decode
    always @* begin
        if (mode_r[`DEB_FIELD_HI])
            deb_len = `DEB_LONG;
        else if (mode_r[`DEB_FIELD_LO])
            deb_len = `DEB_SHORT;
        else
            deb_len = 3'h0;
    end

    line_sync u_scl_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .din     (scl_in),
        .deb_len (deb_len),
        .dout    (scl_f)
    );

    line_sync u_sda_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .din     (sda_in),
        .deb_len (3'h0),
        .dout    (sda_f)
    );

    bit_engine u_bits (
        .clk        (clk),
        .rst_b      (rst_b),
        .scl        (scl_f),
        .sda        (sda_f),
        .scl_rise   (scl_rise),
        .scl_fall   (scl_fall),
        .start_seen (start_seen),
        .stop_seen  (stop_seen)
    );

    // only the slave mode code with the enable bit runs the engine
    assign active = mode_r[`ENABLE_BIT] &&
        (mode_r[`MODE_FIELD_HI:`MODE_FIELD_LO] == `MODE_SLAVE);
    assign wr_mode = reg_wr && reg_addr == `REG_MODE_ENABLE_CONTROL;
    assign wr_stat = reg_wr && reg_addr == `REG_TRANSFER_STATUS_CONTROL;
    assign wr_data = reg_wr && reg_addr == `REG_SERIAL_DATA_BYTE;
    assign wr_irq  = reg_wr && reg_addr == `REG_IRQ_STATUS;
    assign rx_byte = {shift_r[6:0], sda_f};
    assign ev_match = active && state_r == ST_ADDR && scl_rise &&
        bit_cnt_r == 4'h7 && shift_r[6:0] == addr_r[7:1];
    assign ev_done = active && state_r == ST_DATA && scl_rise &&
        bit_cnt_r == 4'h7;

    // bus engine
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            sda_low_r <= 1'b0;
        end else if (!active || stop_seen) begin
            state_r   <= ST_IDLE;
            sda_low_r <= 1'b0;
        end else if (start_seen) begin
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_low_r <= 1'b0;
        end else begin
            case (state_r)
            ST_ADDR: begin
                if (scl_rise) begin
                    shift_r   <= rx_byte;
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (bit_cnt_r == 4'h7)
                        state_r <= ev_match ? ST_AACK : ST_SKIP;
                end
            end
            ST_AACK: begin
                if (scl_fall && !sda_low_r) begin
                    sda_low_r <= 1'b1;
                end else if (scl_fall) begin
                    state_r   <= ST_DATA;
                    bit_cnt_r <= 4'h0;
                    sda_low_r <= stat_r[`DIR_BIT] & ~data_r[7];
                    shift_r   <= data_r;
                end
            end
            ST_DATA: begin
                if (scl_rise) begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (!stat_r[`DIR_BIT])
                        shift_r <= rx_byte;
                    if (bit_cnt_r == 4'h7)
                        state_r <= ST_DACK;
                end else if (scl_fall && stat_r[`DIR_BIT]) begin
                    shift_r   <= {shift_r[6:0], 1'b0};
                    sda_low_r <= ~shift_r[6];
                end
            end
            ST_DACK: begin
                if (scl_fall && stat_r[`DIR_BIT] && sda_low_r) begin
                    sda_low_r <= 1'b0;
                end else if (scl_fall && !stat_r[`DIR_BIT] &&
                             !sda_low_r && bit_cnt_r == 4'h8) begin
                    sda_low_r <= ~stat_r[`TXAK_BIT];
                    bit_cnt_r <= 4'h9;
                end else if (scl_fall && bit_cnt_r == 4'h9) begin
                    state_r   <= ST_DATA;
                    bit_cnt_r <= 4'h0;
                    shift_r   <= data_r;
                    sda_low_r <= stat_r[`DIR_BIT] & ~data_r[7];
                end else if (scl_rise && stat_r[`DIR_BIT]) begin
                    bit_cnt_r <= 4'h9;
                    if (sda_f)
                        state_r <= ST_SKIP;
                end else if (scl_fall && stat_r[`DIR_BIT]) begin
                    bit_cnt_r <= 4'h9;
                end
            end
            default: begin
                sda_low_r <= 1'b0;
            end
            endcase
        end
    end

    // registers and flags
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r     <= `MODE_RESET;
            stat_r     <= `STATUS_RESET;
            data_r     <= `DATA_RESET;
            addr_r     <= `ADDR_RESET;
            toc_r      <= `TOC_RESET;
            irq_stat_r <= 2'h0;
            irq_mask_r <= 2'h0;
            pullup_r   <= `PULLUP_RESET;
            en_d_r     <= 1'b0;
        end else begin
            en_d_r <= mode_r[`ENABLE_BIT];
            if (wr_mode)
                mode_r <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
            if (reg_wr && reg_addr == `REG_OWN_SLAVE_ADDRESS)
                addr_r <= reg_wdata;
            if (reg_wr && reg_addr == `REG_BUS_TIMEOUT_CONTROL)
                toc_r <= reg_wdata;
            if (reg_wr && reg_addr == `REG_IRQ_MASK)
                irq_mask_r <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `REG_PULLUP_CONTROL)
                pullup_r <= reg_wdata[1:0];
            if (wr_stat) begin
                stat_r[`HTX_BIT]  <= reg_wdata[`HTX_BIT];
                stat_r[`TXAK_BIT] <= reg_wdata[`TXAK_BIT];
                stat_r[`DIR_BIT]  <= reg_wdata[`DIR_BIT];
                stat_r[`WAKE_BIT] <= reg_wdata[`WAKE_BIT];
            end
            // received byte lands in the shared data register
            if (ev_done && !stat_r[`DIR_BIT])
                data_r <= rx_byte;
            else if (wr_data)
                data_r <= reg_wdata;
            if (mode_r[`ENABLE_BIT] && !en_d_r) begin
                stat_r[`DONE_BIT]  <= 1'b1;
                stat_r[`MATCH_BIT] <= 1'b0;
                stat_r[`BUSY_BIT]  <= 1'b0;
                stat_r[`DIR_BIT]   <= 1'b0;
                stat_r[`RXAK_BIT]  <= 1'b1;
            end else if (active) begin
                if (start_seen) begin
                    stat_r[`BUSY_BIT]  <= 1'b1;
                    stat_r[`MATCH_BIT] <= 1'b0;
                end
                if (stop_seen)
                    stat_r[`BUSY_BIT] <= 1'b0;
                if (ev_match) begin
                    stat_r[`MATCH_BIT] <= 1'b1;
                    stat_r[`DIR_BIT]   <= sda_f;
                    stat_r[`DONE_BIT]  <= 1'b1;
                end
                if (state_r == ST_DATA && scl_fall && bit_cnt_r == 4'h1)
                    stat_r[`DONE_BIT] <= 1'b0;
                if (ev_done) begin
                    stat_r[`DONE_BIT]  <= 1'b1;
                    stat_r[`MATCH_BIT] <= 1'b0;
                end
                if (state_r == ST_DACK && scl_rise && stat_r[`DIR_BIT])
                    stat_r[`RXAK_BIT] <= sda_f;
            end
            // set wins over write-one-to-clear
            irq_stat_r[`IRQ_DONE_BIT] <= ev_done |
                (irq_stat_r[`IRQ_DONE_BIT] &
                 ~(wr_irq & reg_wdata[`IRQ_DONE_BIT]));
            irq_stat_r[`IRQ_MATCH_BIT] <= ev_match |
                (irq_stat_r[`IRQ_MATCH_BIT] &
                 ~(wr_irq & reg_wdata[`IRQ_MATCH_BIT]));
        end
    end

    // pins, read data and interrupt
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata     <= 8'h00;
            scl_out       <= 1'b0;
            scl_oe_b      <= 1'b1;
            sda_out       <= 1'b0;
            sda_oe_b      <= 1'b1;
            scl_pullup_en <= 1'b0;
            sda_pullup_en <= 1'b0;
            irq           <= 1'b0;
        end else begin
            scl_oe_b      <= 1'b1;
            sda_oe_b      <= ~(active & sda_low_r);
            scl_pullup_en <= pullup_r[0];
            sda_pullup_en <= pullup_r[1];
            irq           <= |(irq_stat_r & irq_mask_r);
            if (!reg_rd)
                reg_rdata <= 8'h00;
            else if (reg_addr == `REG_MODE_ENABLE_CONTROL)
                reg_rdata <= mode_r;
            else if (reg_addr == `REG_TRANSFER_STATUS_CONTROL)
                reg_rdata <= stat_r;
            else if (reg_addr == `REG_SERIAL_DATA_BYTE)
                reg_rdata <= data_r;
            else if (reg_addr == `REG_OWN_SLAVE_ADDRESS)
                reg_rdata <= addr_r;
            else if (reg_addr == `REG_BUS_TIMEOUT_CONTROL)
                reg_rdata <= toc_r;
            else if (reg_addr == `REG_IRQ_STATUS)
                reg_rdata <= {6'h00, irq_stat_r};
            else if (reg_addr == `REG_IRQ_MASK)
                reg_rdata <= {6'h00, irq_mask_r};
            else
                reg_rdata <= {6'h00, pullup_r};
        end
    end
endmodule // i2c_slave_interface
`default_nettype wire

// ### testbench/i2c_slave_interface_assertions.sv
// assertions on the slave's pins, register port and interrupt
// assumes it is bound to the slave core and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module slave_chk (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rd,
    // pins and interrupt
    input wire logic       scl_in,
    input wire logic       scl_out,
    input wire logic       scl_oe_b,
    input wire logic       sda_out,
    input wire logic       sda_oe_b,
    input wire logic       scl_pullup_en,
    input wire logic       sda_pullup_en,
    input wire logic       irq
);
    // enable as written, and cycles since it went off
    logic       on_r;
    logic [3:0] off_r;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            on_r  <= 1'h0;
            off_r <= 4'hF;
        end else begin
            if (reg_wr && reg_addr == 3'h0)
                on_r <= reg_wdata[7:5] == 3'h6 && reg_wdata[1];
            if (on_r)
                off_r <= 4'h0;
            else if (off_r != 4'hF)
                off_r <= off_r + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_scl_free;
        scl_oe_b && !scl_out;
    endproperty
    a_scl_free: assert property (p_scl_free) else $error("scl driven");
    property p_sda_low;
        !sda_out;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda high");
    property p_sda_idle;
        off_r == 4'hF |-> sda_oe_b;
    endproperty
    a_sda_idle: assert property (p_sda_idle) else $error("sda off");
    property p_sda_at_low;
        $changed(sda_oe_b) |-> !scl_in && $past(scl_in, 3) == 1'h0;
    endproperty
    a_sda_at_low: assert property (p_sda_at_low) else $error("sda edge");
    property p_addr_keep;
        reg_wr && reg_addr == 3'h3 ##1 !reg_wr ##1 reg_rd && reg_addr == 3'h3
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_addr_keep: assert property (p_addr_keep) else $error("addr");
    property p_pullup;
        reg_wr && reg_addr == 3'h7 ##1 !reg_wr |=>
            {6'h0, sda_pullup_en, scl_pullup_en} == ($past(reg_wdata, 2) & 8'h03);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pullup");
    property p_irq_mask;
        reg_wr && reg_addr == 3'h6 && reg_wdata[1:0] == 2'h0 ##1 !reg_wr |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq mask");
    property p_irq_clear;
        irq && reg_wr && reg_addr == 3'h5 && reg_wdata[1:0] == 2'h3 ##1 !reg_wr
            |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq clear");
endmodule // slave_chk
bind i2c_slave_interface slave_chk slave_chk_inst (.clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rdata, .reg_rd, .scl_in, .scl_out, .scl_oe_b,
    .sda_out, .sda_oe_b, .scl_pullup_en, .sda_pullup_en, .irq);
`default_nettype wire

// ### testbench/bus_master.sv
// behavioural bus master making the clock and data line levels
// assumes open-drain wiring with pull-ups formed by the bench
`timescale 1ns/10ps
`default_nettype none
module bus_master (
    // lines
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // quarter of a 400 kHz bit, fine for a 20 MHz system clock
    localparam int Q = 625;
    initial begin
        scl      = 1'h1;
        sda_pull = 1'h0;
    end
    task automatic bit_io(input logic b, output logic s);
        #Q sda_pull = !b;
        #Q scl = 1'h1;
        #Q s = sda;
        #Q scl = 1'h0;
    endtask
    task automatic start;
        #(Q + 3) sda_pull = 1'h1;
        #Q scl = 1'h0;
    endtask
    task automatic stop;
        #Q sda_pull = 1'h1;
        #Q scl = 1'h1;
        #Q sda_pull = 1'h0;
        #Q;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'h1, s);
        ack = !s;
    endtask
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, s);
            d[i] = s;
        end
        bit_io(!ack, s);
    endtask
endmodule // bus_master
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench: register tasks, bus master, random traffic
// assumes the master model and checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk, rst_b, reg_wr, reg_rd, ack;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata, a, d, t;
    logic [31:0] seed;
    int          num_errors, compares;
    wire logic [7:0] reg_rdata;
    wire logic   scl_out, scl_oe_b, sda_out, sda_oe_b, scl_pu, sda_pu, irq;
    wire logic   m_scl, m_pull;
    wire logic   scl_line = (scl_oe_b | scl_out) & m_scl;
    wire logic   sda_line = (sda_oe_b | sda_out) & ~m_pull;
    localparam logic [7:0] rst_val [8] = '{8'hE0, 8'h81, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    i2c_slave_interface i2c_slave_interface_inst (
        .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .scl_in(scl_line), .scl_out, .scl_oe_b, .sda_in(sda_line), .sda_out,
        .sda_oe_b, .scl_pullup_en(scl_pu), .sda_pullup_en(sda_pu), .irq);
    bus_master bus_master_inst (.scl(m_scl), .sda_pull(m_pull),
        .sda(sda_line));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] mode_of(input logic [2:0] m,
        input logic [1:0] deb, input logic en);
        return {m, 1'h0, deb, en, 1'h0};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [2:0] ad, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= ad;
        reg_wdata <= v;
        reg_wr    <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [2:0] ad, input logic [7:0] m, e);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd   <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk($sformatf("reg %0d", ad), e, reg_rdata & m);
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        $display("ERROR watchdog expected finish seen timeout");
        final_report;
    end
    initial begin
        seed       = 32'h1B8907CB;
        rst_b      = 1'h0;
        reg_wr     = 1'h0;
        reg_rd     = 1'h0;
        reg_addr   = 3'h0;
        reg_wdata  = 8'h00;
        num_errors = 0;
        compares   = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        foreach (rst_val[i]) rd(i[2:0], 8'hFF, rst_val[i]);
        wr(3'h0, 8'hFF);
        rd(3'h0, 8'hFF, 8'hEF);
        wr(3'h6, 8'h03);
        $display("test registers done");
        for (int deb = 0; deb < 4; deb++) begin
            wr(3'h0, mode_of(3'h6, deb[1:0], 1'h1));
            rd(3'h0, 8'hFF, mode_of(3'h6, deb[1:0], 1'h1));
            a = rnd();
            wr(3'h7, a);
            wr(3'h3, a);
            rd(3'h3, 8'hFF, a);
            chk("pullup", a & 8'h03, {6'h0, sda_pu, scl_pu});
            bus_master_inst.start();
            bus_master_inst.send_byte({a[7:1], 1'h0}, ack);
            chk("addr ack", 8'h01, {7'h0, ack});
            rd(3'h1, 8'h44, 8'h40);
            chk("irq", 8'h01, {7'h0, irq});
            d = rnd();
            bus_master_inst.send_byte(d, ack);
            bus_master_inst.stop();
            chk("data ack", 8'h01, {7'h0, ack});
            rd(3'h2, 8'hFF, d);
            rd(3'h1, 8'h80, 8'h80);
            rd(3'h5, 8'h03, 8'h03);
            wr(3'h6, 8'h00);
            rd(3'h6, 8'hFF, 8'h00);
            chk("irq", 8'h00, {7'h0, irq});
            wr(3'h6, 8'h03);
            wr(3'h5, 8'h03);
            rd(3'h5, 8'h03, 8'h00);
            chk("irq", 8'h00, {7'h0, irq});
            $display("test receive %0d done", deb);
        end
        t = rnd();
        wr(3'h2, t);
        wr(3'h1, 8'h10);
        bus_master_inst.start();
        bus_master_inst.send_byte({a[7:1], 1'h1}, ack);
        rd(3'h1, 8'h44, 8'h44);
        bus_master_inst.recv_byte(1'h1, d);
        chk("tx byte", t, d);
        bus_master_inst.recv_byte(1'h0, d);
        bus_master_inst.stop();
        chk("tx byte", t, d);
        wr(3'h1, 8'h00);
        wr(3'h1, 8'h08);
        d = rnd();
        bus_master_inst.start();
        bus_master_inst.send_byte({a[7:1], 1'h0}, ack);
        bus_master_inst.send_byte(d, ack);
        bus_master_inst.stop();
        chk("nack", 8'h00, {7'h0, ack});
        rd(3'h2, 8'hFF, d);
        wr(3'h1, 8'h00);
        $display("test transmit done");
        for (int k = 0; k < 3; k++) begin
            wr(3'h0, mode_of(k == 1 ? 3'h5 : 3'h6, 2'h0, k != 2));
            bus_master_inst.start();
            bus_master_inst.send_byte({a[7:1] ^ {6'h0, k == 0}, 1'h0}, ack);
            bus_master_inst.stop();
            chk("refused ack", 8'h00, {7'h0, ack});
        end
        $display("test refuse done");
        @(posedge clk);
        rst_b <= 1'h0;
        @(posedge clk);
        rst_b <= 1'h1;
        rd(3'h0, 8'hFF, 8'hE0);
        $display("test second reset done");
        final_report;
    end
endmodule // tb_top
`default_nettype wire
